// File: rtl/sfp_defs.vh
// Constants for the serial flash program command sequencer
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

// Command codes
`define SFP_OP_PP 8'h02
`define SFP_OP_DIFP 8'hA2
`define SFP_OP_XDIFP 8'hD2
`define SFP_OP_QIFP 8'h32
`define SFP_OP_XQIFP 8'h38
`define SFP_OP_CLRFSR 8'h50
`define SFP_OP_WREN 8'h06
`define SFP_OP_WRDI 8'h04
`define SFP_OP_SUSP 8'h75
`define SFP_OP_RESUME 8'h7A

// Protocol modes on proto_mode_i
`define SFP_MODE_EXT 2'h0
`define SFP_MODE_DUAL 2'h1
`define SFP_MODE_QUAD 2'h2

// Page geometry
`define SFP_PAGE_BYTES 256
`define SFP_COL_W 8
`define SFP_ADDR_W 24
`define SFP_SECT_HI 23
`define SFP_SECT_LO 20
`define SFP_NUM_SECT 16

// Flag status bit positions
`define SFP_FSR_READY 7
`define SFP_FSR_ERASE_ERR 5
`define SFP_FSR_PROG_ERR 4
`define SFP_FSR_PROG_SUSP 2
`define SFP_FSR_PROT_ERR 1

// Reset values
`define SFP_RST_FLAG 1'b0

// Timing
`define SFP_CLK_PERIOD_NS 8
`define SFP_PROG_TMO_NS 1000000
`define SFP_PROG_TMO_CYC (`SFP_PROG_TMO_NS / `SFP_CLK_PERIOD_NS)
`define SFP_TMO_W 20

`endif

// File: rtl/sfp_page_ram.v
// Page staging buffer with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "sfp_defs.vh"
module sfp_page_ram (
  input wire core_clk_i,
  input wire wr_en_i,
  input wire [`SFP_COL_W-1:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire rd_en_i,
  input wire [`SFP_COL_W-1:0] rd_addr_i,
  output reg [7:0] rd_data_o
);
  reg [7:0] mem_q [0:`SFP_PAGE_BYTES-1];

  always @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end
endmodule
`default_nettype wire

// File: rtl/sfp_prog_seq.v
// Serial flash program and clear-flag command sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sfp_defs.vh"
// Functional notes
// - Command 50h clears the erase, program and protection error flags.
// - Command lanes: one in extended, two in dual, four in quad mode.
// - Select raised off a byte boundary: no program, no flags, latch stays.
// - Address bits are sampled on the rising serial clock edge.
// - Protected target: reject, latch stays 1, flag bits 1 and 4 set.
// - Program timeout clears the latch and sets the program fail flag.
// - Programming only clears bits; a 1 over a stored 0 leaves it.
// - Decode 02h page program, A2h dual and D2h extended dual program.
// - Decode 32h quad and 38h extended quad input program.
// - Write-in-progress reads 1 while programming, 0 once finished.
// - Write enable latch clears at program end, on success or timeout.
// - Suspend pauses a running program; resume continues it.
// - Bytes past page end wrap to the start of the same page.
// - Over a page of bytes: only the last page-size bytes are kept.
// - Under a page of bytes: other bytes of the page stay untouched.
// - Suspending a program sets flag status bit 2.
module sfp_prog_seq #(
  parameter [`SFP_TMO_W-1:0] PROG_TMO_CYC = `SFP_PROG_TMO_CYC
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire spi_cs_n_i,
  input wire spi_sck_i,
  input wire [3:0] spi_dq_i,
  input wire [1:0] proto_mode_i,
  input wire [`SFP_NUM_SECT-1:0] sect_prot_i,
  input wire [7:0] arr_rdata_i,
  input wire arr_ack_i,
  output reg arr_wr_o,
  output wire [`SFP_ADDR_W-1:0] arr_addr_o,
  output reg [7:0] arr_wdata_o,
  output wire wip_o,
  output wire wel_o,
  output wire [7:0] flag_status_o
);
  localparam [1:0] PH_CMD = 2'h0;
  localparam [1:0] PH_ADDR = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;
  localparam [1:0] PH_SKIP = 2'h3;
  localparam [1:0] E_IDLE = 2'h0;
  localparam [1:0] E_SCAN = 2'h1;
  localparam [1:0] E_RD = 2'h2;
  localparam [1:0] E_WR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  reg sck_prev_q;
  reg cs_prev_q;
  wire cs_n_s = sync2_q[5];
  wire sck_s = sync2_q[4];
  wire [3:0] dq_s = sync2_q[3:0];

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      sync1_q <= 6'h20;
      sync2_q <= 6'h20;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sync1_q <= {spi_cs_n_i, spi_sck_i, spi_dq_i};
      sync2_q <= sync1_q;
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_n_s;
    end
  end

  wire cs_fall = cs_prev_q & ~cs_n_s;
  wire cs_rise = ~cs_prev_q & cs_n_s;
  wire sck_rise = ~cs_n_s & sck_s & ~sck_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame state
  reg [1:0] phase_q;
  reg [7:0] op_q;
  reg [7:0] sh_q;
  reg [3:0] bitcnt_q;
  reg [1:0] acnt_q;
  reg [`SFP_ADDR_W-1:0] addr_q;
  reg [`SFP_COL_W-1:0] col_q;
  reg data_seen_q;
  reg single_q;
  reg wel_q;
  reg wip_q;
  reg susp_q;
  reg prog_err_q;
  reg prot_err_q;
  reg erase_err_q;
  reg [1:0] eng_q;

  wire op_dual = (op_q == `SFP_OP_DIFP) | (op_q == `SFP_OP_XDIFP);
  wire op_quad = (op_q == `SFP_OP_QIFP) | (op_q == `SFP_OP_XQIFP);

  reg [3:0] lane_w;
  always @* begin
    if (proto_mode_i == `SFP_MODE_DUAL) begin
      lane_w = 4'h2;
    end else if (proto_mode_i == `SFP_MODE_QUAD) begin
      lane_w = 4'h4;
    end else if (phase_q == PH_ADDR && op_q == `SFP_OP_XDIFP) begin
      lane_w = 4'h2;
    end else if (phase_q == PH_ADDR && op_q == `SFP_OP_XQIFP) begin
      lane_w = 4'h4;
    end else if (phase_q == PH_DATA && op_dual) begin
      lane_w = 4'h2;
    end else if (phase_q == PH_DATA && op_quad) begin
      lane_w = 4'h4;
    end else begin
      lane_w = 4'h1;
    end
  end

  reg [7:0] sh_d;
  always @* begin
    case (lane_w)
      4'h1: sh_d = {sh_q[6:0], dq_s[0]};
      4'h2: sh_d = {sh_q[5:0], dq_s[1:0]};
      default: sh_d = {sh_q[3:0], dq_s[3:0]};
    endcase
  end

  wire byte_done = sck_rise & ((bitcnt_q + lane_w) == 4'h8);
  wire is_prog_op = (sh_d == `SFP_OP_PP) | (sh_d == `SFP_OP_DIFP) |
                    (sh_d == `SFP_OP_XDIFP) | (sh_d == `SFP_OP_QIFP) |
                    (sh_d == `SFP_OP_XQIFP);
  wire cmd_byte = byte_done & (phase_q == PH_CMD);
  wire buf_we = byte_done & (phase_q == PH_DATA);
  // clear flags once the code is in
  wire clr_flags = cmd_byte & (sh_d == `SFP_OP_CLRFSR);
  wire vld_clr = cmd_byte & is_prog_op & wel_q & ~wip_q;
  // only a whole final byte executes
  wire frame_ok = cs_rise & (bitcnt_q == 4'h0);
  wire prog_end = frame_ok & (phase_q == PH_DATA) & data_seen_q;
  wire prot_hit = sect_prot_i[addr_q[`SFP_SECT_HI:`SFP_SECT_LO]];
  wire set_prot = prog_end & prot_hit;
  wire prog_go = prog_end & ~prot_hit;
  wire sgl_ok = frame_ok & single_q;

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      phase_q <= PH_SKIP;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      bitcnt_q <= 4'h0;
      acnt_q <= 2'h0;
      addr_q <= {`SFP_ADDR_W{1'b0}};
      col_q <= {`SFP_COL_W{1'b0}};
      data_seen_q <= 1'b0;
      single_q <= 1'b0;
    end else if (cs_fall) begin
      phase_q <= PH_CMD;
      bitcnt_q <= 4'h0;
      acnt_q <= 2'h0;
      data_seen_q <= 1'b0;
      single_q <= 1'b0;
    end else if (sck_rise) begin
      sh_q <= sh_d;
      bitcnt_q <= byte_done ? 4'h0 : bitcnt_q + lane_w;
      if (byte_done) begin
        single_q <= 1'b0;
        case (phase_q)
          PH_CMD: begin
            op_q <= sh_d;
            if (vld_clr) begin
              phase_q <= PH_ADDR;
            end else begin
              phase_q <= PH_SKIP;
              single_q <= 1'b1;
            end
          end
          PH_ADDR: begin
            addr_q <= {addr_q[15:0], sh_d};
            acnt_q <= acnt_q + 2'h1;
            if (acnt_q == 2'h2) begin
              phase_q <= PH_DATA;
              col_q <= sh_d;
            end
          end
          PH_DATA: begin
            col_q <= col_q + {{(`SFP_COL_W-1){1'b0}}, 1'b1};
            data_seen_q <= 1'b1;
          end
          default: phase_q <= PH_SKIP;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer and per-byte valid marks
  // page size fixed at 256
  reg [`SFP_PAGE_BYTES-1:0] vld_q;
  reg [8:0] idx_q;
  wire [7:0] buf_rdata;
  wire buf_re = (eng_q == E_SCAN) & ~susp_q & ~idx_q[8] & vld_q[idx_q[7:0]];

  sfp_page_ram u_page (
    .core_clk_i(core_clk_i),
    .wr_en_i(buf_we),
    .wr_addr_i(col_q),
    .wr_data_i(sh_d),
    .rd_en_i(buf_re),
    .rd_addr_i(idx_q[7:0]),
    .rd_data_o(buf_rdata)
  );

  genvar g;
  generate
    for (g = 0; g < `SFP_PAGE_BYTES; g = g + 1) begin : g_vld
      always @(posedge core_clk_i) begin
        if (reset_i || vld_clr) begin
          vld_q[g] <= 1'b0;
        end else if (buf_we && col_q == g) begin
          vld_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Program engine
  reg [`SFP_TMO_W-1:0] tmo_q;
  wire tmo_hit = (eng_q != E_IDLE) & ~susp_q & (tmo_q == PROG_TMO_CYC - 1'b1);
  wire eng_done = (eng_q == E_SCAN) & ~susp_q & idx_q[8];
  wire eng_stop = tmo_hit | eng_done;

  assign arr_addr_o = {addr_q[`SFP_ADDR_W-1:`SFP_COL_W], idx_q[7:0]};

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      eng_q <= E_IDLE;
      idx_q <= 9'h000;
      tmo_q <= {`SFP_TMO_W{1'b0}};
      arr_wr_o <= 1'b0;
      arr_wdata_o <= 8'h00;
    end else if (tmo_hit) begin
      eng_q <= E_IDLE;
      arr_wr_o <= 1'b0;
    end else begin
      if (eng_q != E_IDLE && !susp_q) begin
        tmo_q <= tmo_q + {{(`SFP_TMO_W-1){1'b0}}, 1'b1};
      end
      case (eng_q)
        E_IDLE: begin
          if (prog_go) begin
            eng_q <= E_SCAN;
            idx_q <= 9'h000;
            tmo_q <= {`SFP_TMO_W{1'b0}};
          end
        end
        E_SCAN: begin
          if (!susp_q) begin
            if (idx_q[8]) begin
              eng_q <= E_IDLE;
            end else if (buf_re) begin
              eng_q <= E_RD;
            end else begin
              idx_q <= idx_q + 9'h001;
            end
          end
        end
        E_RD: begin
          arr_wdata_o <= buf_rdata & arr_rdata_i;
          arr_wr_o <= 1'b1;
          eng_q <= E_WR;
        end
        E_WR: begin
          if (arr_ack_i) begin
            arr_wr_o <= 1'b0;
            idx_q <= idx_q + 9'h001;
            eng_q <= E_SCAN;
          end
        end
        default: eng_q <= E_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and flag bits
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      wel_q <= `SFP_RST_FLAG;
      wip_q <= `SFP_RST_FLAG;
      susp_q <= `SFP_RST_FLAG;
      prog_err_q <= `SFP_RST_FLAG;
      prot_err_q <= `SFP_RST_FLAG;
      erase_err_q <= `SFP_RST_FLAG;
    end else begin
      if (eng_stop) begin
        wel_q <= 1'b0;
      end else if (sgl_ok && op_q == `SFP_OP_WREN && !wip_q) begin
        wel_q <= 1'b1;
      end else if (sgl_ok && op_q == `SFP_OP_WRDI && !wip_q && !prot_err_q) begin
        wel_q <= 1'b0;
      end
      if (prog_go && eng_q == E_IDLE) begin
        wip_q <= 1'b1;
      end else if (eng_stop) begin
        wip_q <= 1'b0;
      end
      if (eng_stop) begin
        susp_q <= 1'b0;
      end else if (sgl_ok && op_q == `SFP_OP_SUSP && wip_q) begin
        susp_q <= 1'b1;
      end else if (sgl_ok && op_q == `SFP_OP_RESUME) begin
        susp_q <= 1'b0;
      end
      // set wins, only clear command drops it
      if (tmo_hit) begin
        prog_err_q <= 1'b1;
      end else if (set_prot) begin
        prog_err_q <= 1'b1;
      end else if (clr_flags) begin
        prog_err_q <= 1'b0;
      end
      if (set_prot) begin
        prot_err_q <= 1'b1;
      end else if (clr_flags) begin
        prot_err_q <= 1'b0;
      end
      // Erase path lives elsewhere; bit kept so the clear has a target
      if (clr_flags) begin
        erase_err_q <= 1'b0;
      end
    end
  end

  assign wip_o = wip_q;
  assign wel_o = wel_q;
  assign flag_status_o = {~wip_q, 1'b0, erase_err_q, prog_err_q,
                          1'b0, susp_q, prot_err_q, 1'b0};
endmodule
`default_nettype wire

// File: verif/sfp_host.sv
// Host controller model that drives the serial link
`timescale 1ns/1ns
`default_nettype none
module sfp_host (
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] dq_o
);
  logic [7:0] tx [0:299];
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    dq_o = 4'h0;
  end
  task automatic frame(input int nb, input int lc, input int la, input int ld, input int cut);
    int w;
    cs_n_o = 1'b0;
    for (int i = 0; i < nb + (cut > 0); i++) begin
      w = (i == 0) ? lc : (i < 4) ? la : ld;
      for (int k = 0; k < ((i == nb) ? cut : 8 / w); k++) begin
        dq_o = 4'((tx[i] >> (8 - w * (k + 1))) & ((1 << w) - 1));
        #32 sck_o = 1'b1;
        #32 sck_o = 1'b0;
      end
    end
    #32 cs_n_o = 1'b1;
    // Released lanes must not keep showing the last bit
    dq_o = ~dq_o;
    #64;
  endtask
endmodule
`default_nettype wire

// File: verif/sfp_prog_seq_sva.sv
// Port assertions for the program command sequencer
`timescale 1ns/1ns
`default_nettype none
module sfp_prog_seq_chk #(
  parameter [19:0] PROG_TMO_CYC = 20'h1E848
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire [7:0] arr_rdata_i,
  input wire arr_wr_o,
  input wire [23:0] arr_addr_o,
  input wire [7:0] arr_wdata_o,
  input wire wip_o,
  input wire wel_o,
  input wire [7:0] flag_status_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  logic [19:0] busy_q;
  // Suspended time is not charged against the timeout
  always @(posedge core_clk_i) begin
    if (reset_i || !wip_o) begin
      busy_q <= 20'h0;
    end else if (!flag_status_o[2]) begin
      busy_q <= busy_q + 20'h1;
    end
  end
  chk_end_wel: assert property ($fell(wip_o) |-> !wel_o)
    else $error("latch set after end");
  chk_ready_bit: assert property (flag_status_o[7] == !wip_o)
    else $error("ready bit wrong");
  chk_wr_busy: assert property (arr_wr_o |-> wip_o)
    else $error("write while idle");
  chk_only_clear: assert property (arr_wr_o |-> (arr_wdata_o & ~arr_rdata_i) == 8'h00)
    else $error("bit set by program");
  chk_same_page: assert property (arr_wr_o && $past(wip_o)
    |-> arr_addr_o[23:8] == $past(arr_addr_o[23:8]))
    else $error("page moved");
  chk_prot_pair: assert property ($rose(flag_status_o[1]) |-> flag_status_o[4] && wel_o)
    else $error("protect flags");
  chk_clear_all: assert property ($fell(flag_status_o[4])
    |-> !flag_status_o[5] && !flag_status_o[1])
    else $error("partial clear");
  chk_susp_busy: assert property (flag_status_o[2] |-> wip_o)
    else $error("suspend while idle");
  chk_tmo_bound: assert property (busy_q <= PROG_TMO_CYC + 20'h4)
    else $error("no timeout");
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the program command sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sfp_defs.vh"
module testbench;
  localparam int TMO = 3000;
  logic core_clk_i, reset_i, arr_ack_i, ack_en;
  logic [1:0] proto_mode_i;
  logic [15:0] sect_prot_i, pg;
  logic [7:0] mem [0:255];
  logic [7:0] exp_pg [0:255];
  int bad_count, samples_checked, st, n;
  wire spi_cs_n_i, spi_sck_i, arr_wr_o, wip_o, wel_o;
  wire [3:0] spi_dq_i;
  wire [23:0] arr_addr_o;
  wire [7:0] arr_wdata_o, flag_status_o;
  wire [7:0] arr_rdata_i = mem[arr_addr_o[7:0]];
  logic [7:0] ops [0:7] = '{`SFP_OP_PP, `SFP_OP_DIFP, `SFP_OP_XDIFP, `SFP_OP_QIFP,
    `SFP_OP_XQIFP, `SFP_OP_XDIFP, `SFP_OP_XQIFP, `SFP_OP_QIFP};
  int mds [0:7] = '{0, 0, 0, 0, 0, 1, 2, 0};
  int las [0:7] = '{1, 1, 2, 1, 4, 2, 4, 1};
  int lds [0:7] = '{1, 2, 2, 4, 4, 2, 4, 4};
  sfp_host u_host (.cs_n_o(spi_cs_n_i), .sck_o(spi_sck_i), .dq_o(spi_dq_i));
  sfp_prog_seq #(.PROG_TMO_CYC(20'(TMO))) u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .spi_cs_n_i(spi_cs_n_i), .spi_sck_i(spi_sck_i), .spi_dq_i(spi_dq_i),
    .proto_mode_i(proto_mode_i), .sect_prot_i(sect_prot_i), .arr_rdata_i(arr_rdata_i),
    .arr_ack_i(arr_ack_i), .arr_wr_o(arr_wr_o), .arr_addr_o(arr_addr_o),
    .arr_wdata_o(arr_wdata_o), .wip_o(wip_o), .wel_o(wel_o), .flag_status_o(flag_status_o));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // Array answers late at random
  always @(negedge core_clk_i) begin
    arr_ack_i <= arr_wr_o && ack_en && !arr_ack_i && $urandom_range(1);
  end
  always @(posedge core_clk_i) begin
    if (arr_wr_o && arr_ack_i) begin
      mem[arr_addr_o[7:0]] <= arr_wdata_o;
    end
  end
  function automatic int lanes();
    return (proto_mode_i == `SFP_MODE_QUAD) ? 4 : (proto_mode_i == `SFP_MODE_DUAL) ? 2 : 1;
  endfunction
  function automatic logic [7:0] exp_byte(input logic [7:0] old, input logic [7:0] nw);
    return old & nw;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    u_host.tx[0] = c;
    u_host.frame(1, lanes(), 1, 1, 0);
  endtask
  task automatic prog(input logic [7:0] op, input int la, input int ld, input int s,
    input int k, input int cut);
    u_host.tx[0] = op;
    u_host.tx[1] = pg[15:8];
    u_host.tx[2] = pg[7:0];
    u_host.tx[3] = 8'(s);
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      exp_pg[i] = mem[i];
    end
    for (int i = 0; i <= k; i++) u_host.tx[4 + i] = 8'($urandom);
    for (int i = (k > 256) ? k - 256 : 0; i < k; i++) begin
      exp_pg[(s + i) % 256] = exp_byte(mem[(s + i) % 256], u_host.tx[4 + i]);
    end
    u_host.frame(4 + k, lanes(), la, ld, cut);
  endtask
  task automatic wait_idle();
    int w;
    w = 0;
    while (wip_o !== 1'b0 && w < 4 * TMO) begin
      @(negedge core_clk_i);
      w++;
    end
    if (w >= 4 * TMO) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic check_page();
    for (int i = 0; i < 256; i++) check("page byte", exp_pg[i], mem[i]);
  endtask
  initial begin
    reset_i = 1'b1;
    ack_en = 1'b1;
    proto_mode_i = `SFP_MODE_EXT;
    sect_prot_i = 16'h8000;
    pg = 16'h0123;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(30));
    repeat (8) @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check("flags", 8'h80, flag_status_o);
    prog(`SFP_OP_PP, 1, 1, 0, 4, 0);
    check("wip", 0, wip_o);
    cmd(`SFP_OP_WREN);
    check("wel", 1, wel_o);
    cmd(`SFP_OP_WRDI);
    check("wel", 0, wel_o);
    for (int t = 0; t < 8; t++) begin
      proto_mode_i = 2'(mds[t]);
      cmd(`SFP_OP_WREN);
      st = (t == 0) ? 250 : (t == 7) ? 7 : $urandom_range(255);
      n = (t == 0) ? 12 : (t == 7) ? 260 : $urandom_range(48, 1);
      pg = 16'($urandom_range(16'hEFFF));
      prog(ops[t], las[t], lds[t], st, n, 0);
      check("wip", 1, wip_o);
      wait_idle();
      check("wel", 0, wel_o);
      check("flags", 8'h80, flag_status_o);
      check_page();
    end
    proto_mode_i = `SFP_MODE_EXT;
    cmd(`SFP_OP_WREN);
    prog(`SFP_OP_PP, 1, 1, 0, 3, 1);
    check("wip", 0, wip_o);
    check("wel", 1, wel_o);
    check("flags", 8'h80, flag_status_o);
    pg = 16'hF456;
    prog(`SFP_OP_PP, 1, 1, 0, 3, 0);
    check("wel", 1, wel_o);
    check("flags", 8'h92, flag_status_o);
    pg = 16'h0456;
    prog(`SFP_OP_QIFP, 1, 4, 9, 5, 0);
    wait_idle();
    check("flags", 8'h92, flag_status_o);
    cmd(`SFP_OP_CLRFSR);
    check("flags", 8'h80, flag_status_o);
    ack_en = 1'b0;
    cmd(`SFP_OP_WREN);
    prog(`SFP_OP_PP, 1, 1, 0, 2, 0);
    wait_idle();
    check("wel", 0, wel_o);
    check("flags", 8'h90, flag_status_o);
    cmd(`SFP_OP_CLRFSR);
    cmd(`SFP_OP_WREN);
    prog(`SFP_OP_PP, 1, 1, 30, 2, 0);
    cmd(`SFP_OP_SUSP);
    check("flags", 8'h04, flag_status_o);
    ack_en = 1'b1;
    cmd(`SFP_OP_RESUME);
    wait_idle();
    check("flags", 8'h80, flag_status_o);
    check_page();
    print_verdict();
  end
endmodule
bind sfp_prog_seq sfp_prog_seq_chk #(.PROG_TMO_CYC(PROG_TMO_CYC)) u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .arr_rdata_i(arr_rdata_i),
  .arr_wr_o(arr_wr_o), .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
  .wip_o(wip_o), .wel_o(wel_o), .flag_status_o(flag_status_o));
`default_nettype wire
